/* logic/lcdcf_regs.svh */
// Constants of the LCD command and frame RAM core: opcodes, reset values,
// field positions and sizes. Included by the package and the core.
`ifndef LCDCF_REGS_SVH
`define LCDCF_REGS_SVH

// Frame RAM geometry.
`define LCDCF_NUM_COLS      132
`define LCDCF_NUM_PAGES     9
`define LCDCF_ICON_PAGE     4'h8
`define LCDCF_LAST_COL      8'h83
`define LCDCF_ICON_COM      7'h40
`define LCDCF_LAST_MAIN_COM 6'h3f

// Instruction patterns, matched with casez.
`define LCDCF_OP_COL_LO     8'h0?
`define LCDCF_OP_COL_HI     8'h1?
`define LCDCF_OP_RATIO      8'b0010_0???
`define LCDCF_OP_POWER      8'b0010_1???
`define LCDCF_OP_START      8'b01??_????
`define LCDCF_OP_EV         8'h81
`define LCDCF_OP_SEGREV     8'b1010_000?
`define LCDCF_OP_BIAS       8'b1010_001?
`define LCDCF_OP_ALLON      8'b1010_010?
`define LCDCF_OP_INVERT     8'b1010_011?
`define LCDCF_OP_DISPLAY    8'b1010_111?
`define LCDCF_OP_PAGE       8'hb?
`define LCDCF_OP_COMREV     8'hc?
`define LCDCF_OP_RMW        8'he0
`define LCDCF_OP_SWRESET    8'he2
`define LCDCF_OP_NOP        8'he3
`define LCDCF_OP_END        8'hee
`define LCDCF_OP_BOOST      8'hf8
`define LCDCF_OP_TEST       8'b1111_111?

// Status byte bit positions.
`define LCDCF_STAT_SEGREV   6
`define LCDCF_STAT_DISPOFF  5
`define LCDCF_STAT_RESET    4

// Reset values.
`define LCDCF_RST_RATIO     3'h4
`define LCDCF_RST_CONTRAST  6'h20

`endif

/* logic/lcdcf_pkg.sv */
// Types shared by the LCD command and frame RAM core and its users.
// Assumes lcdcf_regs.svh is on the include path.
`include "lcdcf_regs.svh"

package lcdcf_pkg;

  // One host bus request, taken in a single clock cycle.
  typedef struct packed {
    logic       wr_strobe;
    logic       rd_strobe;
    logic       cmd_data_sel;
    logic [7:0] wdata;
  } lcdcf_host_req_t;

  // Display mode flags seen by the drive logic.
  typedef struct packed {
    logic       display_on;
    logic       seg_reverse;
    logic       com_reverse;
    logic       invert_flag;
    logic       all_on_flag;
    logic       bias_sel;
    logic       power_save;
    logic       rmw_mode;
    logic       test_mode;
    logic [5:0] start_line;
  } lcdcf_mode_t;

  // Settings of the analog power circuits.
  typedef struct packed {
    logic       booster_enable;
    logic       regulator_enable;
    logic       follower_enable;
    logic [2:0] regulation_ratio;
    logic [5:0] contrast_level;
    logic       boost_level;
  } lcdcf_power_t;

  // Second byte expected by a two-byte instruction.
  typedef enum logic [1:0] {
    LCDCF_ARG_NONE  = 2'b00,
    LCDCF_ARG_EV    = 2'b01,
    LCDCF_ARG_BOOST = 2'b10
  } lcdcf_arg_t;

endpackage : lcdcf_pkg

/* logic/lcdcf_core.sv */
// LCD controller core: instruction decoder, frame RAM with page, column
// and start-line pointers, display flags and power settings.
// Assumes a byte front end on clk_sys_in that delivers one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "lcdcf_regs.svh"

module lcdcf_core #(
  parameter int NUM_COLS  = `LCDCF_NUM_COLS,
  parameter int NUM_PAGES = `LCDCF_NUM_PAGES
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    hw_reset_n_in,
  input  wire logic                    serial_if_in,
  input  wire lcdcf_pkg::lcdcf_host_req_t host_req_in,
  input  wire logic [6:0]              scan_com_in,
  input  wire logic [7:0]              scan_seg_in,
  output logic [7:0]                   rd_data_out,
  output logic                         seg_data_out,
  output lcdcf_pkg::lcdcf_mode_t       mode_out,
  output lcdcf_pkg::lcdcf_power_t      power_out
);
  import lcdcf_pkg::*;

  localparam int RAM_WORDS = NUM_COLS * NUM_PAGES;

  // The pointer widths below only cover this geometry.
  if (NUM_COLS != `LCDCF_NUM_COLS || NUM_PAGES != `LCDCF_NUM_PAGES) begin : g_bad
    $error("lcdcf_core serves only a 132 by 9 page frame RAM");
  end

  logic [2:0]   hw_sync_reg;
  logic         hw_level_reg;
  logic         hw_rst_active;
  logic         swrst_busy_reg;
  lcdcf_arg_t   arg_reg;
  lcdcf_mode_t  mode_reg;
  lcdcf_power_t power_reg;
  logic [3:0]   page_reg;
  logic [7:0]   col_reg;
  logic [7:0]   col_next;
  logic [7:0]   rmw_save_reg;
  logic [7:0]   latch_reg;
  logic [7:0]   frame_ram [0:RAM_WORDS-1];
  logic [10:0]  ram_addr;
  logic         ram_addr_ok;
  logic [7:0]   ram_rdata;
  logic         wr_cmd, is_cmd, wr_dat, rd_dat, rd_stat, sw_rst;
  logic         op_col_lo, op_col_hi, op_ratio, op_power, op_start, op_ev;
  logic         op_segrev, op_bias, op_allon, op_invert, op_display;
  logic         op_page, op_comrev, op_rmw, op_end, op_boost, op_test;
  logic [7:0]   cmd_byte;
  logic [5:0]   scan_line;
  logic [5:0]   scan_com_eff;
  logic [7:0]   scan_col;
  logic [10:0]  scan_addr;
  logic [7:0]   scan_byte;
  logic         scan_pixel;
  logic         in_reset;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // The reset pin comes from outside; a level counts once stages two and
  // three agree, which also filters single-cycle glitches.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hw_sync_reg  <= 3'h0;
      hw_level_reg <= 1'b0;
    end else begin
      hw_sync_reg <= {hw_sync_reg[1:0], hw_reset_n_in};
      if (hw_sync_reg[1] == hw_sync_reg[2]) begin
        hw_level_reg <= hw_sync_reg[2];
      end
    end
  end

  assign hw_rst_active = !hw_level_reg;
  assign in_reset      = hw_rst_active | swrst_busy_reg;
  assign cmd_byte      = host_req_in.wdata;

  // Request classification by the select line; only the status read
  // passes while the reset pin is low, and serial mode has no reads.
  assign wr_cmd  = host_req_in.wr_strobe & !host_req_in.cmd_data_sel
                   & !hw_rst_active;
  assign is_cmd  = wr_cmd & (arg_reg == LCDCF_ARG_NONE);
  assign wr_dat  = host_req_in.wr_strobe & host_req_in.cmd_data_sel
                   & !hw_rst_active;
  assign rd_dat  = host_req_in.rd_strobe & host_req_in.cmd_data_sel
                   & !hw_rst_active & !serial_if_in;
  assign rd_stat = host_req_in.rd_strobe & !host_req_in.cmd_data_sel
                   & !serial_if_in;
  assign sw_rst  = is_cmd & (cmd_byte == `LCDCF_OP_SWRESET);

  // Instruction decode; the nop byte matches nothing and so does nothing.
  always_comb begin
    {op_col_lo, op_col_hi, op_ratio, op_power, op_start, op_ev} = 6'h00;
    {op_segrev, op_bias, op_allon, op_invert, op_display} = 5'h00;
    {op_page, op_comrev, op_rmw, op_end, op_boost, op_test} = 6'h00;
    casez (cmd_byte)
      `LCDCF_OP_COL_LO:  op_col_lo  = 1'b1;
      `LCDCF_OP_COL_HI:  op_col_hi  = 1'b1;
      `LCDCF_OP_RATIO:   op_ratio   = 1'b1;
      `LCDCF_OP_POWER:   op_power   = 1'b1;
      `LCDCF_OP_START:   op_start   = 1'b1;
      `LCDCF_OP_EV:      op_ev      = 1'b1;
      `LCDCF_OP_SEGREV:  op_segrev  = 1'b1;
      `LCDCF_OP_BIAS:    op_bias    = 1'b1;
      `LCDCF_OP_ALLON:   op_allon   = 1'b1;
      `LCDCF_OP_INVERT:  op_invert  = 1'b1;
      `LCDCF_OP_DISPLAY: op_display = 1'b1;
      `LCDCF_OP_PAGE:    op_page    = 1'b1;
      `LCDCF_OP_COMREV:  op_comrev  = 1'b1;
      `LCDCF_OP_RMW:     op_rmw     = 1'b1;
      `LCDCF_OP_END:     op_end     = 1'b1;
      `LCDCF_OP_BOOST:   op_boost   = 1'b1;
      `LCDCF_OP_TEST:    op_test    = 1'b1;
      default:           op_col_lo  = 1'b0;
    endcase
  end

  // Two-byte instructions: the next command-write byte is the argument.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arg_reg <= LCDCF_ARG_NONE;
    end else if (hw_rst_active) begin
      arg_reg <= LCDCF_ARG_NONE;
    end else if (wr_cmd) begin
      case (arg_reg)
        LCDCF_ARG_NONE: begin
          if (op_ev) begin
            arg_reg <= LCDCF_ARG_EV;
          end else if (op_boost) begin
            arg_reg <= LCDCF_ARG_BOOST;
          end
        end
        default: arg_reg <= LCDCF_ARG_NONE;
      endcase
    end
  end

  // Reset status is shown for one cycle after a software reset.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      swrst_busy_reg <= 1'b0;
    end else begin
      swrst_busy_reg <= sw_rst;
    end
  end

  // Display mode flags. Some clear on either reset, some on the pin only.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg <= '0;
    end else if (hw_rst_active) begin
      mode_reg <= '0;
    end else if (sw_rst) begin
      mode_reg.com_reverse <= 1'b0;
      mode_reg.rmw_mode    <= 1'b0;
      mode_reg.test_mode   <= 1'b0;
      mode_reg.start_line  <= 6'h00;
    end else if (is_cmd) begin
      if (op_display) mode_reg.display_on  <= cmd_byte[0];
      if (op_segrev)  mode_reg.seg_reverse <= cmd_byte[0];
      if (op_invert)  mode_reg.invert_flag <= cmd_byte[0];
      if (op_allon)   mode_reg.all_on_flag <= cmd_byte[0];
      if (op_bias)    mode_reg.bias_sel    <= cmd_byte[0];
      if (op_comrev)  mode_reg.com_reverse <= cmd_byte[3];
      if (op_start)   mode_reg.start_line  <= cmd_byte[5:0];
      if (op_rmw)     mode_reg.rmw_mode    <= 1'b1;
      if (op_end)     mode_reg.rmw_mode    <= 1'b0;
      if (op_test)    mode_reg.test_mode   <= 1'b1;
    end
  end

  // Power save is the compound of display off and all pixels on.
  always_comb begin
    mode_out            = mode_reg;
    mode_out.power_save = !mode_reg.display_on & mode_reg.all_on_flag;
  end

  // Power circuit settings and the two-byte arguments.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_reg                  <= '0;
      power_reg.regulation_ratio <= `LCDCF_RST_RATIO;
      power_reg.contrast_level   <= `LCDCF_RST_CONTRAST;
    end else if (hw_rst_active) begin
      power_reg                  <= '0;
      power_reg.regulation_ratio <= `LCDCF_RST_RATIO;
      power_reg.contrast_level   <= `LCDCF_RST_CONTRAST;
    end else if (sw_rst) begin
      power_reg.regulation_ratio <= `LCDCF_RST_RATIO;
      power_reg.contrast_level   <= `LCDCF_RST_CONTRAST;
    end else if (wr_cmd && arg_reg == LCDCF_ARG_EV) begin
      power_reg.contrast_level <= cmd_byte[5:0];
    end else if (wr_cmd && arg_reg == LCDCF_ARG_BOOST) begin
      power_reg.boost_level <= cmd_byte[0];
    end else if (is_cmd && op_power) begin
      power_reg.booster_enable   <= cmd_byte[2];
      power_reg.regulator_enable <= cmd_byte[1];
      power_reg.follower_enable  <= cmd_byte[0];
    end else if (is_cmd && op_ratio) begin
      power_reg.regulation_ratio <= cmd_byte[2:0];
    end
  end

  assign power_out = power_reg;

  // Column advance after a data access; wraps at the last column and
  // never touches the page, so the host moves pages itself.
  always_comb begin
    if (col_reg == `LCDCF_LAST_COL) begin
      col_next = 8'h00;
    end else begin
      col_next = col_reg + 8'h01;
    end
  end

  // Page and column pointers with the read-modify-write bookmark.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_reg     <= 4'h0;
      col_reg      <= 8'h00;
      rmw_save_reg <= 8'h00;
    end else if (hw_rst_active || sw_rst) begin
      page_reg <= 4'h0;
      col_reg  <= 8'h00;
    end else if (is_cmd) begin
      if (op_page)   page_reg     <= cmd_byte[3:0];
      if (op_col_hi) col_reg[7:4] <= cmd_byte[3:0];
      if (op_col_lo) col_reg[3:0] <= cmd_byte[3:0];
      if (op_rmw)    rmw_save_reg <= col_reg;
      if (op_end && mode_reg.rmw_mode) col_reg <= rmw_save_reg;
    end else if (wr_dat || (rd_dat && !mode_reg.rmw_mode)) begin
      col_reg <= col_next;
    end
  end

  // Host side RAM address; out of range pointers touch nothing.
  assign ram_addr    = 11'(page_reg * NUM_COLS + col_reg);
  assign ram_addr_ok = (page_reg < 4'(NUM_PAGES))
                       && (col_reg < 8'(NUM_COLS));
  assign ram_rdata   = ram_addr_ok ? frame_ram[ram_addr] : 8'h00;

  // Frame RAM write straight from the bus byte; icon page keeps bit 0.
  // No reset: contents are undefined until the host fills them.
  always_ff @(posedge clk_sys_in) begin
    if (wr_dat && ram_addr_ok) begin
      if (page_reg == `LCDCF_ICON_PAGE) begin
        frame_ram[ram_addr] <= {7'h00, cmd_byte[0]};
      end else begin
        frame_ram[ram_addr] <= cmd_byte;
      end
    end
  end

  // Bus latch: a data read hands out its old contents and then reloads
  // from the current address, which is why the first read is a dummy.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      latch_reg <= 8'h00;
    end else if (rd_dat) begin
      latch_reg <= ram_rdata;
    end
  end

  // Read data stand for the one cycle after the read strobe only.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_dat) begin
      rd_data_out <= latch_reg;
    end else if (rd_stat) begin
      rd_data_out                     <= 8'h00;
      rd_data_out[`LCDCF_STAT_SEGREV]  <= mode_reg.seg_reverse;
      rd_data_out[`LCDCF_STAT_DISPOFF] <= !mode_reg.display_on;
      rd_data_out[`LCDCF_STAT_RESET]   <= in_reset;
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  // Scan side: common number to RAM line through reverse and start line.
  // The icon common bypasses both, so it never scrolls.
  assign scan_com_eff = mode_reg.com_reverse
                        ? (`LCDCF_LAST_MAIN_COM - scan_com_in[5:0])
                        : scan_com_in[5:0];
  assign scan_line = scan_com_eff + mode_reg.start_line;
  assign scan_col  = mode_reg.seg_reverse
                     ? (`LCDCF_LAST_COL - scan_seg_in) : scan_seg_in;
  assign scan_addr = (scan_com_in == `LCDCF_ICON_COM)
                     ? 11'(8 * NUM_COLS + scan_col)
                     : 11'(scan_line[5:3] * NUM_COLS + scan_col);
  assign scan_byte = (scan_col < 8'(NUM_COLS)) ? frame_ram[scan_addr]
                                               : 8'h00;
  assign scan_pixel = (scan_com_in == `LCDCF_ICON_COM) ? scan_byte[0]
                      : scan_byte[scan_line[2:0]];

  // Output data latch: display modes act here and never on the RAM.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seg_data_out <= 1'b0;
    end else if (!mode_reg.display_on) begin
      seg_data_out <= 1'b0;
    end else if (mode_reg.all_on_flag) begin
      seg_data_out <= 1'b1;
    end else begin
      seg_data_out <= scan_pixel ^ mode_reg.invert_flag;
    end
  end

  // Checks on the behaviour above.
  chk_dummy_read: assert property (
    rd_dat |=> rd_data_out == $past(latch_reg))
    else $error("data read did not return the old bus latch");

  chk_write_store: assert property (
    (wr_dat && ram_addr_ok && page_reg != `LCDCF_ICON_PAGE)
    |=> frame_ram[$past(ram_addr)] == $past(host_req_in.wdata))
    else $error("data write not stored at the pointer");

  chk_icon_bit: assert property (
    (rd_dat && page_reg == `LCDCF_ICON_PAGE && ram_addr_ok)
    |=> latch_reg[7:1] == 7'h00)
    else $error("icon page returned more than bit 0");

  chk_col_advance: assert property (
    (wr_dat && !sw_rst && col_reg < `LCDCF_LAST_COL)
    |=> col_reg == $past(col_reg) + 8'h01 && $stable(page_reg))
    else $error("column did not advance by one on write");

  chk_col_wrap: assert property (
    (wr_dat && col_reg == `LCDCF_LAST_COL) |=> col_reg == 8'h00)
    else $error("column did not wrap after last column");

  chk_rmw_hold: assert property (
    (rd_dat && mode_reg.rmw_mode) |=> $stable(col_reg))
    else $error("read moved column in read-modify-write");

  // Requests are two cycles apart here, the spacing of an idle-separated
  // host, so three writes move the column before the end restores it.
  chk_rmw_restore: assert property (
    (is_cmd && op_rmw) ##2 wr_dat ##2 wr_dat ##2 wr_dat
    ##2 (is_cmd && op_end) |=> col_reg == $past(col_reg, 9))
    else $error("end did not restore the saved column");

  chk_hw_reset_hold: assert property (
    hw_rst_active[*2] |-> !mode_reg.display_on && col_reg == 8'h00
    && power_reg.contrast_level == `LCDCF_RST_CONTRAST)
    else $error("state moved while reset pin was low");

  chk_status_word: assert property (
    rd_stat |=> rd_data_out == {1'b0, $past(mode_reg.seg_reverse),
    !$past(mode_reg.display_on), $past(in_reset), 4'h0})
    else $error("status byte wrong");

  chk_ev_arg: assert property (
    (is_cmd && op_ev) ##2 wr_cmd
    |=> power_reg.contrast_level == $past(host_req_in.wdata[5:0]))
    else $error("contrast argument not taken");

  chk_display_off: assert property (
    (!mode_reg.display_on)[*2] |-> !seg_data_out)
    else $error("segment data driven while display off");

  cov_rmw_cycle: cover property (
    (is_cmd && op_rmw) ##[1:20] (is_cmd && op_end));
  cov_dummy_pair: cover property (rd_dat ##1 rd_dat);
  cov_icon_write: cover property (wr_dat && page_reg == `LCDCF_ICON_PAGE);
  cov_sw_reset: cover property (sw_rst ##1 rd_stat);

endmodule // lcdcf_core
`default_nettype wire

/* verif/lcdcf_host.sv */
// Host processor model that issues one-cycle bus requests to the core.
// Assumes the bench calls xfer and that both share clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module lcdcf_host (
  input  wire logic                      clk_sys_in,
  input  wire logic [7:0]                rd_data_in,
  output var  lcdcf_pkg::lcdcf_host_req_t req_out
);
  import lcdcf_pkg::*;

  // The bus idles with no strobe from time zero.
  initial req_out = '0;

  // One transfer per call; a free edge follows, so strobes never merge.
  // Released data lines carry the inverse so stale bytes cannot match.
  task automatic xfer(input logic wr, input logic ds, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_sys_in);
    req_out <= '{wr_strobe: wr, rd_strobe: !wr, cmd_data_sel: ds, wdata: d};
    @(posedge clk_sys_in);
    req_out <= '{wr_strobe: 1'b0, rd_strobe: 1'b0, cmd_data_sel: ds, wdata: ~d};
    @(negedge clk_sys_in);
    q = rd_data_in;
  endtask
endmodule // lcdcf_host
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the LCD core against a behavioural host-side model.
// Assumes the core and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lcdcf_pkg::*;
  logic            clk_sys_in, reset_n_in, hw_reset_n_in, serial_if_in;
  logic [6:0]      scan_com_in;
  logic [7:0]      scan_seg_in, rd_data_out, q;
  logic [31:0]     r;
  logic            seg_data_out;
  lcdcf_host_req_t host_req;
  lcdcf_mode_t     mode_out, em;
  lcdcf_power_t    power_out, ep;
  int              err_count, num_checks, cycles, seed;
  int              ram [9][132];
  int              pg, col, scol, latch, arg;
  bit              hwr;
  logic [7:0]      flg [5] = '{8'hae, 8'ha0, 8'ha6, 8'ha4, 8'ha2};

  lcdcf_core lcdcf_core_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .hw_reset_n_in(hw_reset_n_in), .serial_if_in(serial_if_in),
    .host_req_in(host_req), .scan_com_in(scan_com_in),
    .scan_seg_in(scan_seg_in), .rd_data_out(rd_data_out),
    .seg_data_out(seg_data_out), .mode_out(mode_out), .power_out(power_out));
  lcdcf_host lcdcf_host_i (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data_out),
    .req_out(host_req));

  // Free-running 200 MHz clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // A hang is cut short well beyond the expected run of some 3500 cycles.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  // Counts and reports one comparison.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Defaults of the model; a pin reset clears more than the soft one.
  task automatic mreset(input bit hw);
    if (hw) begin
      em = '0;
      ep = '0;
      arg = 0;
      latch = -1;
    end
    em.start_line = 6'h00;
    em.com_reverse = 1'b0;
    em.rmw_mode = 1'b0;
    em.test_mode = 1'b0;
    pg = 0;
    col = 0;
    ep.regulation_ratio = 3'h4;
    ep.contrast_level = 6'h20;
  endtask

  // Mode and power outputs against the model.
  task automatic chkmp();
    em.power_save = !em.display_on & em.all_on_flag;
    chk("mode", 32'(em), 32'(mode_out));
    chk("power", 32'(ep), 32'(power_out));
  endtask

  // Instruction write with the model's decode beside it.
  task automatic cmd(input logic [7:0] b);
    lcdcf_host_i.xfer(1'b1, 1'b0, b, q);
    if (!hwr) begin
      if (arg == 1) ep.contrast_level = b[5:0];
      else if (arg == 2) ep.boost_level = b[0];
      else casez (b)
        8'h0?: col = (col & 8'hf0) | b[3:0];
        8'h1?: col = {b[3:0], 4'h0} | (col & 15);
        8'b0010_0???: ep.regulation_ratio = b[2:0];
        8'b0010_1???: {ep.booster_enable, ep.regulator_enable,
                       ep.follower_enable} = b[2:0];
        8'b01??_????: em.start_line = b[5:0];
        8'hae, 8'haf: em.display_on = b[0];
        8'ha0, 8'ha1: em.seg_reverse = b[0];
        8'ha6, 8'ha7: em.invert_flag = b[0];
        8'ha4, 8'ha5: em.all_on_flag = b[0];
        8'ha2, 8'ha3: em.bias_sel = b[0];
        8'hb?: pg = b[3:0];
        8'hc?: em.com_reverse = b[3];
        8'he0: begin
          em.rmw_mode = 1'b1;
          scol = col;
        end
        8'hee: if (em.rmw_mode) begin
          em.rmw_mode = 1'b0;
          col = scol;
        end
        8'he2: mreset(1'b0);
        8'hfe, 8'hff: em.test_mode = 1'b1;
        default: ;
      endcase
      arg = (arg == 0 && b == 8'h81) ? 1 : (arg == 0 && b == 8'hf8) ? 2 : 0;
    end
    // The reset flag shows for one cycle only, so let it pass.
    if (b == 8'he2) @(posedge clk_sys_in);
    chkmp();
  endtask

  // Column set by its two halves; callers keep it within 0..131.
  task automatic setcol(input int c);
    cmd(8'h10 | 8'(c >> 4));
    cmd(8'(c & 15));
  endtask

  // Display data write; the icon page keeps bit 0 only.
  task automatic dwr(input logic [7:0] d);
    lcdcf_host_i.xfer(1'b1, 1'b1, d, q);
    if (!hwr) begin
      ram[pg][col] = (pg == 8) ? int'(d & 8'h01) : int'(d);
      col = (col + 1) % 132;
    end
  endtask

  // Display data read: the answer is the latch from the previous read.
  task automatic drd();
    lcdcf_host_i.xfer(1'b0, 1'b1, 8'h00, q);
    if (serial_if_in) chk("serial read", 32'h0, 32'(q));
    else begin
      if (latch >= 0) chk("data read", latch, 32'(q));
      latch = ram[pg][col];
      if (!em.rmw_mode) col = (col + 1) % 132;
    end
  endtask

  // Status read; refused in serial mode.
  task automatic srd();
    lcdcf_host_i.xfer(1'b0, 1'b0, 8'h00, q);
    chk("status", serial_if_in ? 32'h0 : 32'({1'b0, em.seg_reverse,
        !em.display_on, hwr, 4'h0}), 32'(q));
  endtask

  // One pixel of the drive path, seen one cycle after its address.
  task automatic scan(input int c, input int s);
    int ln;
    int cl;
    int e;
    @(posedge clk_sys_in);
    scan_com_in <= 7'(c);
    scan_seg_in <= 8'(s);
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    ln = (c == 64) ? 64 : ((em.com_reverse ? 63 - c : c) + em.start_line) % 64;
    cl = em.seg_reverse ? 131 - s : s;
    e = (ram[ln / 8][cl] >> (ln % 8)) & 1;
    e = !em.display_on ? 0 : em.all_on_flag ? 1 : e ^ int'(em.invert_flag);
    chk("pixel", e, 32'(seg_data_out));
  endtask

  // Counts, verdict and end of run.
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: fill, random traffic, serial mode, pin reset.
  initial begin
    seed = 32'h774cbd4d;
    {reset_n_in, serial_if_in, hwr} = '0;
    hw_reset_n_in = 1'b1;
    scan_com_in = '0;
    scan_seg_in = '0;
    mreset(1'b1);
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chkmp();
    for (int p = 0; p < 9; p++) begin
      cmd(8'hb0 | 8'(p));
      setcol(0);
      for (int c = 0; c < 132; c++) dwr(8'($random(seed)));
    end
    cmd(8'haf);
    setcol(130);
    repeat (5) drd();
    cmd(8'he0);
    repeat (3) dwr(8'($random(seed)));
    cmd(8'hee);
    repeat (2) drd();
    repeat (400) begin
      r = $random(seed);
      case (r[31:24] % 8'd12)
        0: cmd(8'hb0 | 8'(r[3:0] % 4'd9));
        1: setcol(int'(r[15:8] % 8'd132));
        2: dwr(r[7:0]);
        3: drd();
        4: srd();
        5: scan(int'(r[6:0] % 7'd65), int'(r[15:8] % 8'd132));
        6: cmd(flg[r[10:8] % 3'd5] | 8'(r[0]));
        7: cmd(8'hc0 | 8'(r[3:0]));
        8: cmd(8'h20 | 8'(r[3:0]));
        9: cmd(8'h40 | 8'(r[5:0]));
        10: begin
          cmd(r[9] ? 8'h81 : 8'hf8);
          if (r[4]) dwr(r[7:0]);
          cmd(r[23:16] & 8'h3f);
        end
        default: cmd(r[1] ? (r[0] ? 8'he3 : 8'he2) : (r[0] ? 8'hee : 8'he0));
      endcase
    end
    @(posedge clk_sys_in) serial_if_in <= 1'b1;
    drd();
    srd();
    dwr(8'h5a);
    @(posedge clk_sys_in) serial_if_in <= 1'b0;
    cmd(8'ha1);
    cmd(8'h2f);
    cmd(8'hff);
    cmd(8'he2);
    @(posedge clk_sys_in) hw_reset_n_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    hwr = 1'b1;
    mreset(1'b1);
    chkmp();
    srd();
    cmd(8'haf);
    dwr(8'h33);
    @(posedge clk_sys_in) hw_reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    hwr = 1'b0;
    srd();
    cmd(8'haf);
    repeat (2) drd();
    repeat (20) scan(int'($unsigned($random(seed)) % 65), 131);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
